// ===== verilog/sram_ctrl.sv
// host controller sequencing the strobes of an async static memory
`timescale 1ns/10ps
`include "sram_ctrl_params.svh"
module sram_ctrl
   import sram_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // user request
   input  wire logic               req_valid,
   output logic                    req_ready,
   input  wire logic               req_write,
   input  wire logic [`ADDR_W-1:0] req_addr,
   input  wire logic [`DATA_W-1:0] req_wdata,
   // user read answer
   output logic                    rd_valid,
   output logic      [`DATA_W-1:0] rd_data,
   // memory pins
   output logic      [`ADDR_W-1:0] mem_addr,
   output logic                    mem_cs_n,
   output logic                    mem_oe_n,
   output logic                    mem_we_n,
   input  wire logic [`DATA_W-1:0] mem_dq_in,
   output logic      [`DATA_W-1:0] mem_dq_out,
   output logic                    mem_dq_oe
);

   ////////////////////////////////////////////////////////////////////////
   // constants sized for the counter
   localparam logic [`CNT_W-1:0] read_cnt  = `CNT_W'(`READ_CYC - 1);
   localparam logic [`CNT_W-1:0] write_cnt = `CNT_W'(`WRITE_CYC - 1);
   localparam logic [`CNT_W-1:0] turn_cnt  = `CNT_W'(`TURN_CYC - 1);

   ctrl_state_t        state_q;
   ctrl_state_t        state_d;
   logic [`CNT_W-1:0]  cnt_q;
   logic [`CNT_W-1:0]  cnt_d;
   logic [`ADDR_W-1:0] addr_q;
   logic [`DATA_W-1:0] wdata_q;
   logic               cs_n_q;
   logic               oe_n_q;
   logic               we_n_q;
   logic               dq_oe_q;
   logic               rd_valid_q;
   logic [`DATA_W-1:0] rd_data_q;
   logic [`DATA_W-1:0] dq_sync;

   // pin data is asynchronous to us, so it is synchronised first
   sram_data_sync u_sync
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .pin_in   (mem_dq_in),
      .sync_out (dq_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode
   wire cnt_done = (cnt_q == '0);
   wire take     = req_valid && req_ready;
   assign req_ready = (state_q == st_idle);

   // next state: read, write and turn phases last whole counted cycles
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_done ? cnt_q : cnt_q - `CNT_W'(1);
      case (state_q)
         st_idle:
         begin
            if (take)
            begin
               state_d = req_write ? st_write : st_read;
               cnt_d   = req_write ? write_cnt : read_cnt;
            end
         end
         st_read:
         begin
            if (cnt_done)
            begin
               state_d = st_turn;
               cnt_d   = turn_cnt;
            end
         end
         st_write:
         begin
            if (cnt_done)
               state_d = st_wend;
         end
         st_wend:
            state_d = st_idle;
         st_turn:
         begin
            if (cnt_done)
               state_d = st_idle;
         end
         default:
            state_d = st_idle;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // pin strobes from state; all pins are registered
   wire active_nxt = (state_d == st_read) || (state_d == st_write)
                     || (state_d == st_wend);
   // select stays low through wend so write ends on we rising
   wire cs_n_nxt   = !active_nxt;
   wire oe_n_nxt   = !(state_d == st_read);
   wire we_n_nxt   = !(state_d == st_write);
   // data driven for the whole write and one cycle past we rising
   wire dq_oe_nxt  = (state_d == st_write) || (state_d == st_wend);

   // state and pin registers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_q <= st_idle;
         cnt_q   <= '0;
         cs_n_q  <= 1'b1;
         oe_n_q  <= 1'b1;
         we_n_q  <= 1'b1;
         dq_oe_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         cs_n_q  <= cs_n_nxt;
         oe_n_q  <= oe_n_nxt;
         we_n_q  <= we_n_nxt;
         dq_oe_q <= dq_oe_nxt;
      end
   end

   // address and data latched at acceptance, held to cycle end
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         addr_q  <= '0;
         wdata_q <= '0;
      end
      else if (take)
      begin
         addr_q  <= req_addr;
         wdata_q <= req_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read capture at the last read cycle; synchroniser delay is in READ_CYC
   wire rd_capture = (state_q == st_read) && cnt_done;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rd_valid_q <= 1'b0;
         rd_data_q  <= '0;
      end
      else
      begin
         rd_valid_q <= rd_capture;
         if (rd_capture)
            rd_data_q <= dq_sync;
      end
   end

   // outputs
   assign mem_addr   = addr_q;
   assign mem_cs_n   = cs_n_q;
   assign mem_oe_n   = oe_n_q;
   assign mem_we_n   = we_n_q;
   assign mem_dq_out = wdata_q;
   assign mem_dq_oe  = dq_oe_q;
   assign rd_valid   = rd_valid_q;
   assign rd_data    = rd_data_q;

endmodule : sram_ctrl

// ===== verilog/sram_ctrl_params.svh
// timing constants and pin widths for the static memory controller
// What this block does
// - read while select and output enable low
// - write during select and write enable overlap
// - cycle time 12, 15 or 20 ns
// - address presented on the same edge that select falls for reads
// - address valid 10/12/15ns before write end
// - select low 10/12/15ns before write end
// - write data valid 7/8/9ns before end
// - stretch write pulse if output enable low
// - minimum write pulse 10/12/15ns otherwise
// - controller never drives while memory drives
`ifndef SRAM_CTRL_PARAMS_SVH
`define SRAM_CTRL_PARAMS_SVH

`define ADDR_W 18
`define DATA_W 4
`define CLK_PERIOD_NS 20
// slowest grade figures, so any grade is served
`define T_CYCLE_NS 20
`define T_ACCESS_NS 20
`define T_WRITE_PULSE_NS 15
`define T_DATA_SETUP_NS 9
`define T_TURNOFF_NS 8
`define T_ADDR_HOLD_NS 4
// least times round up to whole cycles, at least one
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read: access time plus two cycles for the input synchroniser
`define READ_CYC (`NS_TO_CYC(`T_ACCESS_NS) + 2)
// write pulse covers turn-off plus minimum write pulse (oe held high anyway)
`define WRITE_CYC `NS_TO_CYC(`T_WRITE_PULSE_NS + `T_TURNOFF_NS)
// idle cycles after a read so the memory has floated before we drive
`define TURN_CYC `NS_TO_CYC(`T_TURNOFF_NS)
`define CNT_W 4

`endif

// ===== verilog/sram_ctrl_pkg.sv
// types shared by the static memory controller
package sram_ctrl_pkg;
   typedef enum logic [2:0]
   {
      st_idle,
      st_read,
      st_write,
      st_wend,
      st_turn
   } ctrl_state_t;
endpackage : sram_ctrl_pkg

// ===== verilog/sram_data_sync.sv
// two-stage synchroniser for the memory data pins
`timescale 1ns/10ps
`include "sram_ctrl_params.svh"
module sram_data_sync
(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // asynchronous pin value and its synchronised copy
   input  wire logic [`DATA_W-1:0] pin_in,
   output logic      [`DATA_W-1:0] sync_out
);
   logic [`DATA_W-1:0] meta_q;

   // first stage is read by the second stage only
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule : sram_data_sync

// ===== bench/sram_model.sv
// behavioural async static memory facing the controller
`timescale 1ns/10ps
`include "sram_ctrl_params.svh"
module sram_model
(
   // memory pins
   input  wire logic [`ADDR_W-1:0] mem_addr,
   input  wire logic               mem_cs_n,
   input  wire logic               mem_oe_n,
   input  wire logic               mem_we_n,
   input  wire logic [`DATA_W-1:0] dq_w,
   output wire logic [`DATA_W-1:0] dq_mem
);
   logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
   logic [`DATA_W-1:0] last = 4'h0;
   wire                drive = !mem_cs_n && !mem_oe_n && mem_we_n;
   // no clock, no refresh: contents start cleared and stay
   initial
      foreach (mem[i])
         mem[i] = 4'h0;
   // drives only when selected and reading; else shows a stale inverse
   assign #8 dq_mem = drive ? mem[mem_addr] : ~last;
   always @(negedge drive)
      last = mem[mem_addr];
   // the write lands at the end of the select and write overlap
   always @(posedge mem_we_n)
      if (!mem_cs_n)
         mem[mem_addr] = dq_w;
   always @(posedge mem_cs_n)
      if (!mem_we_n)
         mem[mem_addr] = dq_w;
endmodule : sram_model

// ===== bench/sram_ctrl_chk.sv
// port assertions for the static memory controller
`timescale 1ns/10ps
`include "sram_ctrl_params.svh"
module sram_ctrl_chk
(
   // watched ports
   input wire logic               clock,
   input wire logic               rst_n,
   input wire logic               req_valid,
   input wire logic               req_ready,
   input wire logic               req_write,
   input wire logic [`ADDR_W-1:0] req_addr,
   input wire logic               rd_valid,
   input wire logic [`ADDR_W-1:0] mem_addr,
   input wire logic               mem_cs_n,
   input wire logic               mem_oe_n,
   input wire logic               mem_we_n,
   input wire logic [`DATA_W-1:0] mem_dq_out,
   input wire logic               mem_dq_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire take = req_valid && req_ready;
   a_read_seq: assert property (take && !req_write |=>
      (!mem_cs_n && !mem_oe_n && mem_we_n)[*3] ##1
      (rd_valid && mem_cs_n && !req_ready) ##1 req_ready)
      else $error("read sequence wrong");
   a_write_seq: assert property (take && req_write |=>
      (!mem_cs_n && !mem_we_n && mem_oe_n && mem_dq_oe)[*2] ##1
      (mem_we_n && mem_oe_n && !mem_cs_n && mem_dq_oe && !req_ready)
      ##1 (req_ready && mem_cs_n && !mem_dq_oe))
      else $error("write sequence wrong");
   a_no_fight: assert property (!(mem_dq_oe && !mem_oe_n))
      else $error("bus contention");
   a_addr_take: assert property (take |=> mem_addr == $past(req_addr))
      else $error("address not presented");
   a_addr_quiet: assert property (!take |=> $stable(mem_addr))
      else $error("address moved");
   // a reset also lifts write enable; only a clean write end counts
   a_data_hold: assert property ($rose(mem_we_n) && $past(rst_n) |->
      $stable(mem_dq_out) && mem_dq_oe && $past(!mem_we_n, 2))
      else $error("write data not held");
   a_cs_hold: assert property ($fell(mem_cs_n) |=> !mem_cs_n)
      else $error("select too short");
   a_idle_off: assert property (req_ready |-> mem_we_n && mem_oe_n)
      else $error("strobe low in idle");
   c_read: cover property (take && !req_write);
   c_write: cover property (take && req_write);
   c_back: cover property (rd_valid ##1 take);
endmodule : sram_ctrl_chk
bind sram_ctrl sram_ctrl_chk u_chk (.*);

// ===== bench/sram_ctrl_bench.sv
// random traffic through the static memory controller
`timescale 1ns/10ps
`include "sram_ctrl_params.svh"
module sram_ctrl_bench;
   logic clock = 0, rst_n = 0, req_valid = 0, req_write = 0;
   logic req_ready, rd_valid, mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe;
   logic [`ADDR_W-1:0] req_addr = '0, mem_addr;
   logic [`DATA_W-1:0] req_wdata = '0, rd_data, mem_dq_out, dq_mem;
   logic [`DATA_W-1:0] shadow [logic [`ADDR_W-1:0]];
   int                 bad_count = 0, checks_done = 0, seed = 59, n;
   logic [31:0]        r;
   // the controller owns the wire only while it enables its driver
   wire [`DATA_W-1:0] dq_w = mem_dq_oe ? mem_dq_out : dq_mem;
   always #10 clock = ~clock;
   sram_ctrl u_dut (.*, .mem_dq_in(dq_w));
   sram_model u_mem (.*);
   ////////////////////////////////////////////////////////////////////////
   task check(input string s, input logic [3:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s: want %h got %h", s, e, g);
      end
   endtask : check
   task conclude;
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   function logic [3:0] expect_rd(input logic [`ADDR_W-1:0] a);
      return shadow.exists(a) ? shadow[a] : 4'h0;
   endfunction : expect_rd
   // bounded wait at falling edges for ready or the read answer
   task wait_hi(input bit rd);
      n = 0;
      while ((rd ? rd_valid : req_ready) !== 1'b1 && n < 20)
      begin
         @(negedge clock);
         n++;
      end
      check("handshake", 4'h1, n < 20);
   endtask : wait_hi
   // valid drops right after the take so a request is never taken twice
   task op(input logic w, input logic [`ADDR_W-1:0] a, input logic [3:0] d);
      wait_hi(0);
      req_valid = 1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(negedge clock);
      req_valid = 0;
      wait_hi(!w);
      if (w)
         shadow[a] = d;
      else
      begin
         check("read data", expect_rd(a), rd_data);
         @(negedge clock);
         check("read pulse", 4'h0, rd_valid);
      end
   endtask : op
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(negedge clock);
      check("reset pins", 4'he, {mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe});
      rst_n = 1;
      // two address pages so reads hit written words and both ends
      for (int i = 0; i < 400; i++)
      begin
         r = $random(seed);
         op(r[9], {{14{r[4]}}, r[3:0]}, r[8:5]);
      end
      // reset in mid-write must release every strobe at once
      wait_hi(0);
      req_valid = 1;
      req_write = 1;
      req_addr = 18'h1_2345;
      @(negedge clock);
      req_valid = 0;
      rst_n = 0;
      @(negedge clock);
      check("abort pins", 4'he, {mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe});
      rst_n = 1;
      op(0, 18'h3_ffff, 4'h0);
      conclude();
   end
   initial
   begin
      #400000;
      bad_count++;
      conclude();
   end
endmodule : sram_ctrl_bench
